// ### src/wdrt_pkg.sv
package wdrt_pkg;
  // counter geometry
  localparam int CNT_W = 24;
  localparam logic [23:0] CNT_ZERO = 24'h000000;
  localparam logic [23:0] CNT_WRAP = 24'h0fffff;
  localparam logic [23:0] RELOAD_RST = 24'h0fffff;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RELOAD = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_RSTAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_ST = 8'h10;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h14;
  // control register fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_REFRESH = 1;
  localparam int CTRL_STOP = 2;
  // status fields (ctrl readback and reset status)
  localparam int ST_TIMEOUT = 8;
  localparam int ST_STOP = 9;
  // interrupt status / mask fields
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_STOPREC = 1;
  localparam int IRQ_W = 2;
  // count tick divider: one tick per this many clocks
  localparam int TICK_DIV = 4;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ### src/wdrt_tick.sv
`timescale 1ns/1ns
`default_nettype none
module wdrt_tick
  import wdrt_pkg::*;
#(
  parameter int DIV = TICK_DIV
)
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic run, // divider runs while high
  output logic tick // one-cycle count enable
);
  localparam int DW = (DIV > 1) ? $clog2(DIV) : 1;
  logic [DW-1:0] div_ff;

  initial
  begin
    if (DIV < 1)
      $error("tick divider must be at least one");
  end

  // free divider, held at zero while idle so the first tick is a full period away
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      div_ff <= '0;
      tick <= 1'b0;
    end
    else if (div_ff == DW'(DIV - 1))
    begin
      div_ff <= '0;
      tick <= 1'b1;
    end
    else
    begin
      div_ff <= div_ff + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### src/wdrt_top.sv
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module wdrt_top
  import wdrt_pkg::*;
(
  input wire logic aclk, // 25 MHz system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  output logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  input wire logic [7:0] s_axi_araddr, // read address
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  input wire logic refresh_insn, // refresh instruction strobe from core
  input wire logic debug_mode, // debugger holds core in debug mode
  input wire logic stop_mode, // device is in stop mode
  input wire logic timeout_response_select, // option bit: 1 reset, 0 interrupt
  output logic watchdog_irq, // watchdog interrupt request (level)
  output logic sys_reset_req, // one-cycle system reset request
  output logic stop_recovery_req, // one-cycle stop recovery request
  output logic irq // masked summary interrupt
);
  logic dbg_s1_ff, dbg_s2_ff, stp_s1_ff, stp_s2_ff, rsel_s1_ff, rsel_s2_ff;
  logic resp_reset_ff, cfg_taken_ff;
  logic [1:0] cfg_wait_ff;
  logic en_ff, run_ff;
  logic [23:0] reload_ff, cnt_ff;
  logic tick;
  logic timeout_flag_ff, stop_flag_ff, block_ff;
  logic [IRQ_W-1:0] irq_st_ff, irq_msk_ff;
  logic aw_ff, w_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic wr_fire, rd_fire, rd_rstat, ref_req, timeout;
  logic [31:0] rd_val;
  logic [IRQ_W-1:0] evt;

  // pin-level inputs are synchronised; first stages feed only the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dbg_s1_ff <= 1'b0;
      dbg_s2_ff <= 1'b0;
      stp_s1_ff <= 1'b0;
      stp_s2_ff <= 1'b0;
      rsel_s1_ff <= 1'b0;
      rsel_s2_ff <= 1'b0;
    end
    else
    begin
      dbg_s1_ff <= debug_mode;
      dbg_s2_ff <= dbg_s1_ff;
      stp_s1_ff <= stop_mode;
      stp_s2_ff <= stp_s1_ff;
      rsel_s1_ff <= timeout_response_select;
      rsel_s2_ff <= rsel_s1_ff;
    end
  end

  // capture response once
  // taken once the synchroniser has flushed, so its reset zeros are never mistaken for the option
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_wait_ff <= 2'h0;
      cfg_taken_ff <= 1'b0;
      resp_reset_ff <= 1'b0;
    end
    else
    begin
      if (cfg_wait_ff != 2'h3)
        cfg_wait_ff <= cfg_wait_ff + 2'h1;
      if (!cfg_taken_ff && cfg_wait_ff == 2'h2)
      begin
        cfg_taken_ff <= 1'b1;
        resp_reset_ff <= rsel_s2_ff;
      end
    end
  end

  // axi write channel: address and data accepted in either order
  assign wr_fire = aw_ff && w_ff && !s_axi_bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_ff && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_ff && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awaddr_ff)
          OFF_CTRL, OFF_RELOAD, OFF_COUNT, OFF_RSTAT, OFF_IRQ_ST, OFF_IRQ_MSK:
            s_axi_bresp <= RESP_OKAY;
          default:
            s_axi_bresp <= RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // software control: enable and reload value (byte lanes honoured)
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_ff <= 1'b0;
      reload_ff <= RELOAD_RST;
      irq_msk_ff <= '0;
    end
    else if (wr_fire)
    begin
      if (awaddr_ff == OFF_CTRL && wstrb_ff[0])
        en_ff <= wdata_ff[CTRL_EN];
      if (awaddr_ff == OFF_RELOAD)
      begin
        for (int b = 0; b < 3; b++)
          if (wstrb_ff[b])
            reload_ff[b*8 +: 8] <= wdata_ff[b*8 +: 8];
      end
      if (awaddr_ff == OFF_IRQ_MSK && wstrb_ff[0])
        irq_msk_ff <= wdata_ff[IRQ_W-1:0];
    end
  end

  // refresh sources
  // core instruction or a software write of the refresh bit both count as a refresh
  assign ref_req = refresh_insn
    || (wr_fire && awaddr_ff == OFF_CTRL && wstrb_ff[0] && wdata_ff[CTRL_REFRESH]);

  wdrt_tick u_tick
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run_ff),
    .tick(tick)
  );

  // zero is seen on the tick that would go below it
  assign timeout = run_ff && tick && cnt_ff == CNT_ZERO && !dbg_s2_ff && !ref_req;

  // down-counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_ff <= 1'b0;
      cnt_ff <= RELOAD_RST;
    end
    else if (!en_ff)
      run_ff <= 1'b0;
    else if (!run_ff)
    begin
      run_ff <= 1'b1;
      cnt_ff <= reload_ff;
    end
    else if (dbg_s2_ff || ref_req)
      cnt_ff <= reload_ff;
    else if (timeout)
      cnt_ff <= CNT_WRAP;
    else if (tick)
      cnt_ff <= cnt_ff - 24'h000001;
  end

  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_rstat = rd_fire && s_axi_araddr == OFF_RSTAT;

  // stop flag too
  // set beats the read-clear in the same cycle so no time-out is lost
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timeout_flag_ff <= 1'b0;
      stop_flag_ff <= 1'b0;
      watchdog_irq <= 1'b0;
      sys_reset_req <= 1'b0;
      stop_recovery_req <= 1'b0;
      block_ff <= 1'b0;
    end
    else
    begin
      sys_reset_req <= timeout && resp_reset_ff;
      stop_recovery_req <= 1'b0;
      if (rd_rstat)
      begin
        timeout_flag_ff <= 1'b0;
        stop_flag_ff <= 1'b0;
        watchdog_irq <= 1'b0;
        block_ff <= 1'b1;
      end
      else if (ref_req)
        block_ff <= 1'b0;
      if (timeout && !resp_reset_ff && !(block_ff && !rd_rstat))
      begin
        timeout_flag_ff <= 1'b1;
        watchdog_irq <= 1'b1;
        block_ff <= 1'b0;
        if (stp_s2_ff)
        begin
          stop_flag_ff <= 1'b1;
          stop_recovery_req <= 1'b1;
        end
      end
    end
  end

  // sticky interrupt status, write one to clear, set wins
  assign evt = {timeout && stp_s2_ff && !resp_reset_ff, timeout && !resp_reset_ff};
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_st_ff <= '0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr_fire && awaddr_ff == OFF_IRQ_ST && wstrb_ff[0])
        irq_st_ff <= (irq_st_ff & ~wdata_ff[IRQ_W-1:0]) | evt;
      else
        irq_st_ff <= irq_st_ff | evt;
      irq <= |(irq_st_ff & irq_msk_ff);
    end
  end

  // read mux
  always_comb
  begin
    rd_val = '0;
    case (s_axi_araddr)
      OFF_CTRL:
      begin
        rd_val[CTRL_EN] = en_ff;
        rd_val[CTRL_STOP] = stp_s2_ff;
        rd_val[ST_TIMEOUT] = timeout_flag_ff;
        rd_val[ST_STOP] = stop_flag_ff;
      end
      OFF_RELOAD: rd_val[23:0] = reload_ff;
      OFF_COUNT: rd_val[23:0] = cnt_ff;
      OFF_RSTAT:
      begin
        rd_val[ST_TIMEOUT] = timeout_flag_ff;
        rd_val[ST_STOP] = stop_flag_ff;
      end
      OFF_IRQ_ST: rd_val[IRQ_W-1:0] = irq_st_ff;
      OFF_IRQ_MSK: rd_val[IRQ_W-1:0] = irq_msk_ff;
      default: rd_val = '0;
    endcase
  end

  // axi read channel, one beat after address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        case (s_axi_araddr)
          OFF_CTRL, OFF_RELOAD, OFF_COUNT, OFF_RSTAT, OFF_IRQ_ST, OFF_IRQ_MSK:
            s_axi_rresp <= RESP_OKAY;
          default:
            s_axi_rresp <= RESP_SLVERR;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // assertions
  // wrap value after interrupt time-out
  a_wrap_after_timeout: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout && !resp_reset_ff && en_ff |=> cnt_ff == CNT_WRAP)
    else $error("counter did not wrap after time-out");
  a_tick_decrement: assert property (@(posedge aclk) disable iff (!aresetn)
    run_ff && en_ff && tick && !dbg_s2_ff && !ref_req && cnt_ff != CNT_ZERO
    |=> cnt_ff == $past(cnt_ff) - 24'h000001)
    else $error("count tick did not decrement");
  a_refresh_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    run_ff && en_ff && ref_req |=> cnt_ff == $past(reload_ff))
    else $error("refresh did not reload counter");
  a_enable_load: assert property (@(posedge aclk) disable iff (!aresetn)
    !run_ff && en_ff |=> run_ff && cnt_ff == $past(reload_ff))
    else $error("enable did not load counter");
  a_debug_no_timeout: assert property (@(posedge aclk) disable iff (!aresetn)
    dbg_s2_ff && run_ff && en_ff |=> cnt_ff == $past(reload_ff))
    else $error("debug mode did not keep counter refreshed");
  a_reset_response: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout && resp_reset_ff |=> sys_reset_req && !watchdog_irq)
    else $error("reset mode time-out missed reset request");
  a_irq_response: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout && !resp_reset_ff && !block_ff |=> watchdog_irq && timeout_flag_ff)
    else $error("interrupt mode time-out missed flag or request");
  a_read_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_rstat && !timeout |=> !timeout_flag_ff && !watchdog_irq)
    else $error("status read did not clear flag");
  a_stop_recovery: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout && !resp_reset_ff && !block_ff && stp_s2_ff |=> stop_recovery_req ##1 !stop_recovery_req)
    else $error("stop recovery pulse wrong");
  a_stop_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_recovery_req |-> timeout_flag_ff && stop_flag_ff)
    else $error("stop time-out flags not both set");
  a_option_static: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_taken_ff |=> $stable(resp_reset_ff))
    else $error("response option changed after capture");

  c_irq_timeout: cover property (@(posedge aclk) disable iff (!aresetn) timeout && !resp_reset_ff);
  c_reset_timeout: cover property (@(posedge aclk) disable iff (!aresetn) sys_reset_req);
  c_stop_timeout: cover property (@(posedge aclk) disable iff (!aresetn) stop_recovery_req);
  c_read_clear: cover property (@(posedge aclk) disable iff (!aresetn) rd_rstat && timeout_flag_ff);
endmodule
`default_nettype wire

// ### tb/watchdog_refresh_timeout_tb.sv
`timescale 1ns/1ns
`default_nettype none
module watchdog_refresh_timeout_tb;
  import wdrt_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, vec_count;
  logic [31:0] wdata, rdata, rd, c1;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic refresh_insn, debug_mode, stop_mode, resp_sel, watchdog_irq, sys_reset_req, stop_recovery_req, irq;
  logic kick, sleep, int_en;
  int failures, tests_run, rst_cnt, rec_cnt, n;

  wdrt_top wdrt_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .refresh_insn(refresh_insn),
    .debug_mode(debug_mode), .stop_mode(stop_mode), .timeout_response_select(resp_sel),
    .watchdog_irq(watchdog_irq), .sys_reset_req(sys_reset_req), .stop_recovery_req(stop_recovery_req), .irq(irq));
  wdrt_core_model wdrt_core_model_inst (.aclk(aclk), .aresetn(aresetn), .kick(kick), .sleep(sleep),
    .int_en(int_en), .watchdog_irq(watchdog_irq), .stop_recovery_req(stop_recovery_req),
    .refresh_insn(refresh_insn), .stop_mode(stop_mode), .vec_count(vec_count));

  // clock, 40 ns period
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // count one-cycle pulses as they are sampled, so none is missed
  always @(posedge aclk)
  begin
    if (aresetn && sys_reset_req === 1'b1) rst_cnt++;
    if (aresetn && stop_recovery_req === 1'b1) rec_cnt++;
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  // both channels offered together; each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin aw_ok = 1'b1; awvalid <= 1'b0; end
      if (!w_ok && wready === 1'b1) begin w_ok = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd32(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic kick_once();
    @(posedge aclk);
    kick <= 1'b1;
    @(posedge aclk);
    kick <= 1'b0;
  endtask
  task automatic end_test(input string s);
    $display("test %s finished, %0d mismatches so far", s, failures);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog of the bench: the whole run needs about a thousand cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    failures++;
    $display("MISMATCH t=%0t bench timeout", $time);
    summarize();
  end

  // main sequence
  initial
  begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hf; debug_mode = 1'b0; resp_sel = 1'b0;
    kick = 1'b0; sleep = 1'b0; int_en = 1'b1; failures = 0; tests_run = 0; rst_cnt = 0; rec_cnt = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd32(OFF_RELOAD, rd); chk32(rd, {8'h00, RELOAD_RST});
    rd32(OFF_CTRL, rd); chk32(rd, 32'h0);
    rd32(8'h40, rd); chk32({rd[31:2], resp}, {30'h0, RESP_SLVERR});
    wr(8'h40, 32'h1); chk32({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(OFF_RELOAD, 32'h20); chk32({30'h0, resp}, {30'h0, RESP_OKAY});
    end_test("registers");
    wr(OFF_CTRL, 32'h1);
    rd32(OFF_COUNT, c1); chk_bit(c1 <= 32'h20 && c1 >= 32'h1d, 1'b1);
    repeat (40) @(posedge aclk);
    rd32(OFF_COUNT, rd); chk_bit(rd < c1 && rd + 32'd13 > c1, 1'b1);
    end_test("count");
    repeat (50) begin kick_once(); repeat (4) @(posedge aclk); end
    chk_bit(watchdog_irq, 1'b0);
    rd32(OFF_COUNT, rd); chk_bit(rd >= 32'h1c && rd <= 32'h20, 1'b1);
    end_test("refresh");
    debug_mode <= 1'b1;
    repeat (200) @(posedge aclk);
    rd32(OFF_COUNT, rd); chk32(rd, 32'h20);
    chk_bit(watchdog_irq, 1'b0);
    debug_mode <= 1'b0;
    end_test("debug");
    n = 0;
    while (watchdog_irq !== 1'b1 && n < 300) begin @(posedge aclk); n++; end
    chk_bit(watchdog_irq, 1'b1);
    chk32(rst_cnt, 32'h0);
    rd32(OFF_CTRL, rd); chk32(rd & 32'h300, 32'h100);
    rd32(OFF_COUNT, rd); chk_bit(rd >= 32'h0ffff0 && rd <= {8'h00, CNT_WRAP}, 1'b1);
    rd32(OFF_IRQ_ST, rd); chk32(rd & 32'h1, 32'h1);
    chk_bit(irq, 1'b0);
    rd32(OFF_RSTAT, rd); chk32(rd & 32'h100, 32'h100);
    repeat (2) @(posedge aclk);
    chk_bit(watchdog_irq, 1'b0);
    rd32(OFF_CTRL, rd); chk32(rd & 32'h100, 32'h0);
    wr(OFF_IRQ_MSK, 32'h3);
    repeat (3) @(posedge aclk);
    chk_bit(irq, 1'b1);
    wr(OFF_IRQ_ST, 32'h1);
    repeat (3) @(posedge aclk);
    chk_bit(irq, 1'b0);
    rd32(OFF_IRQ_ST, rd); chk32(rd & 32'h3, 32'h0);
    // reload and restart without a refresh: the read block must swallow the next time-out
    wr(OFF_RELOAD, 32'h8);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_CTRL, 32'h1);
    repeat (60) @(posedge aclk);
    rd32(OFF_COUNT, rd); chk_bit(rd >= 32'h0ffff0 && rd <= {8'h00, CNT_WRAP}, 1'b1);
    chk_bit(watchdog_irq, 1'b0);
    end_test("interrupt");
    @(posedge aclk);
    sleep <= 1'b1;
    @(posedge aclk);
    sleep <= 1'b0;
    kick_once();
    n = 0;
    while (rec_cnt == 0 && n < 300) begin @(posedge aclk); n++; end
    chk32(rec_cnt, 32'h1);
    repeat (3) @(posedge aclk);
    chk_bit(watchdog_irq, 1'b1);
    rd32(OFF_CTRL, rd); chk32(rd & 32'h300, 32'h300);
    rd32(OFF_IRQ_ST, rd); chk32(rd & 32'h2, 32'h2);
    chk_bit(stop_mode, 1'b0);
    chk32({24'h0, vec_count}, 32'h2);
    rd32(OFF_RSTAT, rd); chk32(rd & 32'h300, 32'h300);
    end_test("stop");
    aresetn <= 1'b0;
    resp_sel <= 1'b1;
    repeat (8) @(posedge aclk);
    rst_cnt = 0;
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    wr(OFF_RELOAD, 32'h8);
    wr(OFF_CTRL, 32'h1);
    n = 0;
    while (rst_cnt == 0 && n < 300) begin @(posedge aclk); n++; end
    chk32(rst_cnt, 32'h1);
    chk_bit(watchdog_irq, 1'b0);
    end_test("reset response");
    summarize();
  end
endmodule
`default_nettype wire

// ### tb/wdrt_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module wdrt_core_model
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic kick, // bench asks for one refresh
  input wire logic sleep, // bench asks to enter stop
  input wire logic int_en, // interrupts globally enabled
  input wire logic watchdog_irq, // request from the watchdog
  input wire logic stop_recovery_req, // wake-up pulse
  output logic refresh_insn, // refresh instruction strobe
  output logic stop_mode, // core is asleep
  output logic [7:0] vec_count // watchdog vector fetches
);
  logic refresh_ff;
  logic stop_ff;
  logic served_ff;
  logic [7:0] vec_ff;
  assign refresh_insn = refresh_ff;
  assign stop_mode = stop_ff;
  assign vec_count = vec_ff;
  always_ff @(posedge aclk)
  begin
    refresh_ff <= aresetn & kick;
  end
  // sleep until the watchdog wakes us; a real core cannot leave stop by itself
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stop_ff <= 1'b0;
    else if (stop_recovery_req)
      stop_ff <= 1'b0;
    else if (sleep)
      stop_ff <= 1'b1;
  end
  // vector fetch once awake, one per request
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vec_ff <= 8'h00;
      served_ff <= 1'b0;
    end
    else if (!watchdog_irq)
      served_ff <= 1'b0;
    else if (int_en && !stop_ff && !served_ff)
    begin
      vec_ff <= vec_ff + 8'h01;
      served_ff <= 1'b1;
    end
  end
endmodule
`default_nettype wire
